// [logic/esl_led_top.sv]
`timescale 1ns/100ps
// Behaviour
// RQ1: adapter operating correctly: module led steady green
// RQ2: unconfigured standby: module led flashes green
// RQ3: major fault: module led steady red
// RQ4: minor fault or bad config: flash red
// RQ5: self test: both duo leds alternate green/red
// RQ6: any connection: network led steady green
// RQ7: ip but no connection: network flashes green
// RQ8: duplicate ip: network led steady red
// RQ9: connection timeout: network flashes red, latched
// RQ10: no ip address: network led off
// RQ11: link led green while link present
// RQ12: activity led flashes on frame traffic
// RQ13: server task not ready: run led off
// RQ14: ready, unconfigured: run flashes 1 Hz
// RQ15: configured, waiting: run flashes 5 Hz
// RQ16: tcp connection established: run steady green
// RQ17: system error: error led 2 Hz, 25 percent
// RQ18: communication error: error led steady red
// RQ19: prescaled flashes, personality input selects set
module esl_led_top #(
  parameter int unsigned CLK_HZ = eslpkg_pkg::CLK_HZ
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  arst_n_i,
  input  wire eslpkg_pkg::esl_mode_t mode_i,
  input  wire eslpkg_pkg::esl_adp_t  adp_i,
  input  wire eslpkg_pkg::esl_srv_t  srv_i,
  input  wire logic [1:0]            link_up_i,
  input  wire logic [1:0]            frame_i,
  output eslpkg_pkg::esl_duo_t       module_status_led_o,
  output eslpkg_pkg::esl_duo_t       network_status_led_o,
  output logic [1:0]                 link_led_o,
  output logic [1:0]                 activity_led_o
);

  // -------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // two flop release of the asynchronous reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // -------------------------------------------------------------
  // flash sources
  // -------------------------------------------------------------
  logic fl_adp;
  logic fl_slow;
  logic fl_fast;
  logic fl_err;

  // flash counts scaled from the clock rate, so a short clock rate
  // gives short flashes without touching the pattern logic
  localparam int unsigned FL_HALF  = CLK_HZ / 1000
                                     * eslpkg_pkg::FLASH_HALF_MS;
  localparam int unsigned SLOW_CYC = CLK_HZ / eslpkg_pkg::RUN_SLOW_HZ;
  localparam int unsigned FAST_CYC = CLK_HZ / eslpkg_pkg::RUN_FAST_HZ;
  localparam int unsigned ERR_CYC  = CLK_HZ / eslpkg_pkg::ERR_HZ;
  localparam int unsigned ERR_ON   = ERR_CYC / 100 * eslpkg_pkg::ERR_ON_PCT;
  localparam int unsigned ACT_HALF = CLK_HZ / 1000
                                     * eslpkg_pkg::ACT_HALF_MS;

  // RQ19: prescaled flash counters
  esl_flasher #(
    .PERIOD (2 * FL_HALF),
    .ON_CYC (FL_HALF)
  ) u_fl_adp (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .flash_o   (fl_adp)
  );

  esl_flasher #(
    .PERIOD (SLOW_CYC),
    .ON_CYC (SLOW_CYC / 2)
  ) u_fl_slow (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .flash_o   (fl_slow)
  );

  esl_flasher #(
    .PERIOD (FAST_CYC),
    .ON_CYC (FAST_CYC / 2)
  ) u_fl_fast (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .flash_o   (fl_fast)
  );

  // RQ17: 2 Hz with quarter on time
  esl_flasher #(
    .PERIOD (ERR_CYC),
    .ON_CYC (ERR_ON)
  ) u_fl_err (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .flash_o   (fl_err)
  );

  // -------------------------------------------------------------
  // connection timeout latch
  // -------------------------------------------------------------
  logic tmo_seen;

  // RQ9: held until a connection is seen with timeout low, or reset
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      tmo_seen <= 1'b0;
    end else if (adp_i.conn_timeout) begin
      tmo_seen <= 1'b1;
    end else if (adp_i.conn_any) begin
      tmo_seen <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // pattern selection
  // -------------------------------------------------------------
  eslpkg_pkg::esl_duo_t next_ms;
  eslpkg_pkg::esl_duo_t next_ns;

  // module status / run led choice
  always_comb begin
    next_ms = '0;
    case (mode_i)
      eslpkg_pkg::ESL_ADAPTER: begin
        if (adp_i.self_test) begin
          // RQ5: alternate green and red
          next_ms.green = fl_adp;
          next_ms.red   = !fl_adp;
        end else if (adp_i.major_fault) begin
          // RQ3: steady red
          next_ms.red = 1'b1;
        end else if (adp_i.minor_fault) begin
          // RQ4: flashing red
          next_ms.red = fl_adp;
        end else if (!adp_i.configured) begin
          // RQ2: standby flash green
          next_ms.green = fl_adp;
        end else begin
          // RQ1: steady green
          next_ms.green = 1'b1;
        end
      end
      eslpkg_pkg::ESL_SERVER: begin
        if (!srv_i.task_ready) begin
          // RQ13: run led off
          next_ms.green = 1'b0;
        end else if (srv_i.tcp_conn) begin
          // RQ16: steady green
          next_ms.green = 1'b1;
        end else if (srv_i.configured) begin
          // RQ15: five hertz flash
          next_ms.green = fl_fast;
        end else begin
          // RQ14: one hertz flash
          next_ms.green = fl_slow;
        end
      end
      default: next_ms = '0;
    endcase
  end

  // network status / error led choice
  always_comb begin
    next_ns = '0;
    case (mode_i)
      eslpkg_pkg::ESL_ADAPTER: begin
        if (adp_i.self_test) begin
          // RQ5: alternate, opposite phase
          next_ns.green = !fl_adp;
          next_ns.red   = fl_adp;
        end else if (!adp_i.ip_held) begin
          // RQ10: off without address
          next_ns = '0;
        end else if (adp_i.dup_ip) begin
          // RQ8: steady red
          next_ns.red = 1'b1;
        end else if (tmo_seen) begin
          // RQ9: flashing red
          next_ns.red = fl_adp;
        end else if (adp_i.conn_any) begin
          // RQ6: steady green
          next_ns.green = 1'b1;
        end else begin
          // RQ7: flashing green
          next_ns.green = fl_adp;
        end
      end
      eslpkg_pkg::ESL_SERVER: begin
        if (srv_i.sys_error) begin
          // RQ17: quarter duty flash
          next_ns.red = fl_err;
        end else begin
          // RQ18: steady red on comm error
          next_ns.red = srv_i.comm_error;
        end
      end
      default: next_ns = '0;
    endcase
  end

  // -------------------------------------------------------------
  // per channel link and activity
  // -------------------------------------------------------------
  logic [1:0] act_raw;

  genvar g;
  generate
    for (g = 0; g < eslpkg_pkg::NUM_CH; g++) begin : g_ch
      // RQ12: stretched activity blink
      esl_act_stretch #(
        .HALF (ACT_HALF)
      ) u_act (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .frame_i   (frame_i[g]),
        .led_o     (act_raw[g])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // output registers
  // -------------------------------------------------------------
  // duo leds registered
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      module_status_led_o  <= '0;
      network_status_led_o <= '0;
    end else begin
      module_status_led_o  <= next_ms;
      network_status_led_o <= next_ns;
    end
  end

  // link and activity registered
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      link_led_o     <= 2'h0;
      activity_led_o <= 2'h0;
    end else begin
      // RQ11: link follows link state
      link_led_o     <= link_up_i;
      activity_led_o <= act_raw;
    end
  end

endmodule // esl_led_top

// [logic/eslpkg_pkg.sv]
package eslpkg_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  // adapter flashing half period in ms (no figure printed, plain choice)
  localparam int unsigned FLASH_HALF_MS   = 500;
  localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / 1000 * FLASH_HALF_MS;
  // run led 1 Hz and 5 Hz, error led 2 Hz
  localparam int unsigned RUN_SLOW_HZ     = 1;
  localparam int unsigned RUN_FAST_HZ     = 5;
  localparam int unsigned ERR_HZ          = 2;
  localparam int unsigned ERR_ON_PCT      = 25;
  localparam int unsigned RUN_SLOW_CYC    = CLK_HZ / RUN_SLOW_HZ;
  localparam int unsigned RUN_FAST_CYC    = CLK_HZ / RUN_FAST_HZ;
  localparam int unsigned ERR_CYC         = CLK_HZ / ERR_HZ;
  localparam int unsigned ERR_ON_CYC      = ERR_CYC / 100 * ERR_ON_PCT;
  // activity flash: stretch a frame pulse seen while idle, in ms
  localparam int unsigned ACT_HALF_MS     = 50;
  localparam int unsigned ACT_HALF_CYC    = CLK_HZ / 1000 * ACT_HALF_MS;
  localparam int unsigned NUM_CH          = 2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {ESL_ADAPTER, ESL_SERVER} esl_mode_t;

  // duo led drive, one bit per colour
  typedef struct packed {
    logic red;
    logic green;
  } esl_duo_t;

  // adapter personality status flags
  typedef struct packed {
    logic self_test;
    logic major_fault;
    logic minor_fault;
    logic configured;
    logic ip_held;
    logic dup_ip;
    logic conn_timeout;
    logic conn_any;
  } esl_adp_t;

  // server personality status flags
  typedef struct packed {
    logic task_ready;
    logic configured;
    logic tcp_conn;
    logic sys_error;
    logic comm_error;
  } esl_srv_t;

endpackage

// [logic/esl_flasher.sv]
`timescale 1ns/100ps
// square or duty-cycled flash generator from a cycle count
module esl_flasher #(
  parameter int unsigned PERIOD = 10,
  parameter int unsigned ON_CYC = 5
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  output logic      flash_o
);
  localparam int unsigned W = $clog2(PERIOD + 1);
  logic [W-1:0] cnt;

  // free running prescaler, on for first ON_CYC cycles
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt     <= '0;
      flash_o <= 1'b0;
    end else begin
      if (cnt == W'(PERIOD - 1)) cnt <= '0;
      else cnt <= cnt + W'(1);
      flash_o <= (cnt < W'(ON_CYC));
    end
  end
endmodule // esl_flasher

// [logic/esl_act_stretch.sv]
`timescale 1ns/100ps
// turns frame pulses into a visible blink sequence
module esl_act_stretch #(
  parameter int unsigned HALF = 10
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic frame_i,
  output logic      led_o
);
  localparam int unsigned W = $clog2(2 * HALF + 1);
  logic [W-1:0] cnt;

  // on for HALF, off for at least HALF + 1; retriggers only when idle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt   <= '0;
      led_o <= 1'b0;
    end else begin
      if (cnt != '0) cnt <= cnt - W'(1);
      else if (frame_i) cnt <= W'(2 * HALF);
      led_o <= (cnt > W'(HALF));
    end
  end
endmodule // esl_act_stretch

// [tb/esl_led_top_asserts.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// led pattern checker
// ----------------------------------------------------------------
module esl_led_top_asserts (
  input wire logic                  clk_sys_i,
  input wire logic                  arst_n_i,
  input wire eslpkg_pkg::esl_mode_t mode_i,
  input wire eslpkg_pkg::esl_adp_t  adp_i,
  input wire eslpkg_pkg::esl_srv_t  srv_i,
  input wire logic [1:0]            link_up_i,
  input wire logic [1:0]            frame_i,
  input wire eslpkg_pkg::esl_duo_t  module_status_led_o,
  input wire eslpkg_pkg::esl_duo_t  network_status_led_o,
  input wire logic [1:0]            link_led_o,
  input wire logic [1:0]            activity_led_o
);
  logic [2:0] up_cnt;
  logic       rdy;
  logic       ad;
  logic       sv;
  // edges since reset release, outputs are zero for the first few
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h4) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  // qualifiers per personality
  assign rdy = (up_cnt == 3'h4);
  assign ad  = rdy && mode_i == eslpkg_pkg::ESL_ADAPTER && !adp_i.self_test;
  assign sv  = rdy && mode_i == eslpkg_pkg::ESL_SERVER;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  a_ms_major: assert property (
    ad && adp_i.major_fault |=> module_status_led_o == 2'h2)
    else $error("module led not steady red on major fault");
  a_ms_ok: assert property (
    ad && !adp_i.major_fault && !adp_i.minor_fault && adp_i.configured
    |=> module_status_led_o == 2'h1)
    else $error("module led not steady green when healthy");
  a_ms_minor: assert property (
    (ad && !adp_i.major_fault && adp_i.minor_fault) [*2]
    |=> !module_status_led_o.green)
    else $error("module led shows green on minor fault");
  a_ms_stby: assert property (
    (ad && !adp_i.major_fault && !adp_i.minor_fault && !adp_i.configured)
    [*2] |=> !module_status_led_o.red)
    else $error("module led shows red in standby");
  a_ns_noip: assert property (
    ad && !adp_i.ip_held |=> network_status_led_o == 2'h0)
    else $error("network led lit without address");
  a_ns_dup: assert property (
    ad && adp_i.ip_held && adp_i.dup_ip |=> network_status_led_o == 2'h2)
    else $error("network led not steady red on duplicate address");
  a_ns_hold: assert property (
    ad && adp_i.ip_held && !adp_i.dup_ip && adp_i.conn_timeout ##1
    (ad && adp_i.ip_held && !adp_i.dup_ip && !adp_i.conn_any) [*2]
    |=> !network_status_led_o.green)
    else $error("timeout indication lost before reconnection");
  a_run_off: assert property (
    sv && !srv_i.task_ready |=> module_status_led_o == 2'h0)
    else $error("run led lit while task not ready");
  a_run_on: assert property (
    sv && srv_i.task_ready && srv_i.tcp_conn |=> module_status_led_o == 2'h1)
    else $error("run led not steady green with connection");
  a_err_comm: assert property (
    sv && !srv_i.sys_error
    |=> network_status_led_o == {$past(srv_i.comm_error), 1'h0})
    else $error("error led does not follow communication error");
  a_self_alt: assert property (
    (rdy && mode_i == eslpkg_pkg::ESL_ADAPTER && adp_i.self_test) [*3]
    |=> module_status_led_o.red != module_status_led_o.green
    && network_status_led_o == ~module_status_led_o)
    else $error("self test leds not alternating");
  a_link_follow: assert property (
    rdy |=> link_led_o == $past(link_up_i))
    else $error("link led does not follow link state");
  c_major: cover property (ad && adp_i.major_fault);
  c_tcp: cover property (sv && srv_i.tcp_conn);
  c_frame: cover property (rdy && frame_i != 2'h0);
endmodule // esl_led_top_asserts

bind esl_led_top esl_led_top_asserts chk_u (
  .clk_sys_i, .arst_n_i, .mode_i, .adp_i, .srv_i, .link_up_i, .frame_i,
  .module_status_led_o, .network_status_led_o, .link_led_o, .activity_led_o
);

// [tb/esl_panel_model.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// front panel: records which lamps lit since the last clear
// ----------------------------------------------------------------
module esl_panel_model (
  input  wire logic       clk_sys_i,
  input  wire logic       clear_i,
  input  wire logic [7:0] led_i,
  output logic [7:0]      lit_o
);
  // sticky per lamp, so a stray flash in a window is never missed
  always_ff @(posedge clk_sys_i) begin
    if (clear_i) begin
      lit_o <= 8'h00;
    end else begin
      lit_o <= lit_o | led_i;
    end
  end
endmodule // esl_panel_model

// [tb/esl_led_top_tb.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// bench for the status led driver
// ----------------------------------------------------------------
module esl_led_top_tb;
  localparam eslpkg_pkg::esl_mode_t AD = eslpkg_pkg::ESL_ADAPTER;
  localparam eslpkg_pkg::esl_mode_t SV = eslpkg_pkg::ESL_SERVER;
  // counters scaled to a short clock rate so each flash fits the run
  localparam int unsigned SIM_HZ   = 1000;
  localparam int unsigned AD_HALF  = SIM_HZ / 1000 * eslpkg_pkg::FLASH_HALF_MS;
  localparam int unsigned AC_HALF  = SIM_HZ / 1000 * eslpkg_pkg::ACT_HALF_MS;
  localparam int unsigned ERR_ON_S = SIM_HZ / 100 * eslpkg_pkg::ERR_ON_PCT;
  logic                  clk_sys_i = 1'h0;
  logic                  arst_n_i  = 1'h0;
  eslpkg_pkg::esl_mode_t mode_i    = AD;
  eslpkg_pkg::esl_adp_t  adp_i     = '0;
  eslpkg_pkg::esl_srv_t  srv_i     = '0;
  logic [1:0]            link_up_i = 2'h0;
  logic [1:0]            frame_i   = 2'h0;
  eslpkg_pkg::esl_duo_t  ms;
  eslpkg_pkg::esl_duo_t  ns;
  logic [1:0]            lnk;
  logic [1:0]            act;
  logic [7:0]            lit;
  logic [7:0]            leds;
  int                    on_n      = 0;
  int                    rise_n    = 0;
  logic                  clr       = 1'h1;
  int                    err_total = 0;
  int                    comparisons = 0;
  int                    cyc       = 0;

  esl_led_top #(.CLK_HZ(SIM_HZ)) dut_u (.clk_sys_i, .arst_n_i, .mode_i,
    .adp_i, .srv_i, .link_up_i, .frame_i, .module_status_led_o(ms),
    .network_status_led_o(ns), .link_led_o(lnk), .activity_led_o(act));
  // lamp order: ms red, ms green, ns red, ns green, link 1..0, act 1..0
  assign leds = {ms, ns, lnk, act};
  esl_panel_model panel_u (.clk_sys_i, .clear_i(clr), .led_i(leds),
    .lit_o(lit));

  // 10 MHz clock
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // apply status flags, then watch the panel for 40 cycles
  task automatic put(input eslpkg_pkg::esl_mode_t m, input logic [7:0] a,
                     input logic [4:0] s);
    @(posedge clk_sys_i);
    mode_i <= m;
    adp_i  <= a;
    srv_i  <= s;
    clr    <= 1'h1;
    repeat (4) @(posedge clk_sys_i);
    clr <= 1'h0;
    repeat (40) @(posedge clk_sys_i);
    #1;
  endtask

  // count on cycles and rising edges of one lamp over n cycles
  task automatic meas(input int idx, input int n);
    logic prev;
    prev   = leds[idx];
    on_n   = 0;
    rise_n = 0;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
      if (leds[idx] === 1'b1) on_n++;
      if (leds[idx] === 1'b1 && prev === 1'b0) rise_n++;
      prev = leds[idx];
    end
  endtask

  // true when the last window showed the expected on time and edges
  function automatic logic fit(input int on, input int rise);
    return (on_n == on) && (rise_n == rise);
  endfunction

  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'h1;
    put(AD, 8'h80, 5'h00);
    chk({4'h0, ms ^ ns}, 8'h03);
    chk({7'h0, ms.red ^ ms.green}, 8'h01);
    meas(7, 2 * AD_HALF);
    chk({7'h0, fit(AD_HALF, 1)}, 8'h01);
    chk({4'h0, lit[7:4]}, 8'h0F);
    put(AD, 8'h60, 5'h00);
    chk({6'h0, ms}, 8'h02);
    put(AD, 8'h30, 5'h00);
    chk({7'h0, lit[6]}, 8'h00);
    meas(7, 2 * AD_HALF);
    chk({7'h0, fit(AD_HALF, 1)}, 8'h01);
    put(AD, 8'h08, 5'h00);
    chk({7'h0, lit[7]}, 8'h00);
    meas(6, 2 * AD_HALF);
    chk({7'h0, fit(AD_HALF, 1)}, 8'h01);
    put(AD, 8'h10, 5'h00);
    chk({4'h0, ms, ns}, 8'h04);
    put(AD, 8'h1C, 5'h00);
    chk({6'h0, ns}, 8'h02);
    put(AD, 8'h19, 5'h00);
    chk({6'h0, ns}, 8'h01);
    put(AD, 8'h18, 5'h00);
    chk({7'h0, lit[5]}, 8'h00);
    meas(4, 2 * AD_HALF);
    chk({7'h0, fit(AD_HALF, 1)}, 8'h01);
    put(AD, 8'h1A, 5'h00);
    put(AD, 8'h18, 5'h00);
    chk({7'h0, lit[4]}, 8'h00);
    meas(5, 2 * AD_HALF);
    chk({7'h0, fit(AD_HALF, 1)}, 8'h01);
    put(AD, 8'h19, 5'h00);
    chk({6'h0, ns}, 8'h01);
    put(AD, 8'h1A, 5'h00);
    @(posedge clk_sys_i);
    arst_n_i <= 1'h0;
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'h1;
    put(AD, 8'h18, 5'h00);
    chk({6'h0, lit[5:4]}, 8'h01);
    put(SV, 8'h19, 5'h01);
    chk({4'h0, ms, ns}, 8'h02);
    put(SV, 8'h00, 5'h14);
    chk({4'h0, ms, ns}, 8'h04);
    put(SV, 8'h00, 5'h18);
    chk({7'h0, lit[7]}, 8'h00);
    meas(6, SIM_HZ);
    chk({7'h0, fit(SIM_HZ / 2, eslpkg_pkg::RUN_FAST_HZ)}, 8'h01);
    put(SV, 8'h00, 5'h10);
    chk({7'h0, lit[7]}, 8'h00);
    meas(6, SIM_HZ);
    chk({7'h0, fit(SIM_HZ / 2, eslpkg_pkg::RUN_SLOW_HZ)}, 8'h01);
    put(SV, 8'h00, 5'h13);
    chk({7'h0, lit[4]}, 8'h00);
    meas(5, SIM_HZ);
    chk({7'h0, fit(ERR_ON_S, eslpkg_pkg::ERR_HZ)}, 8'h01);
    put(AD, 8'h10, 5'h13);
    chk({4'h0, ms, ns}, 8'h04);
    chk({6'h0, act}, 8'h00);
    @(posedge clk_sys_i);
    link_up_i <= 2'h2;
    frame_i   <= 2'h2;
    @(posedge clk_sys_i);
    frame_i <= 2'h0;
    repeat (5) @(posedge clk_sys_i);
    #1;
    chk({4'h0, lnk, act}, 8'h0A);
    @(posedge clk_sys_i);
    link_up_i <= 2'h1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk({6'h0, lnk}, 8'h01);
    @(posedge clk_sys_i);
    frame_i <= 2'h1;
    meas(0, 8 * AC_HALF);
    chk({7'h0, rise_n >= 3}, 8'h01);
    report_and_stop();
  end
endmodule // esl_led_top_tb
